// [src/scan_readout_pkg.sv]
// constants shared by the scan readout configuration block
package scan_readout_pkg;

  // register port
  localparam int REG_ADDR_W = 8;
  localparam int REG_DATA_W = 8;

  // register map
  localparam logic [7:0] VERT_CTRL_ADDR = 8'h11;
  localparam logic [7:0] HORIZ_CTRL_ADDR = 8'h13;
  localparam logic [7:0] INTEG_CFG_ADDR = 8'h15;

  // reset values
  localparam logic [7:0] VERT_CTRL_RST = 8'h04;
  localparam logic [7:0] HORIZ_CTRL_RST = 8'h04;
  localparam logic [7:0] INTEG_CFG_RST = 8'h08;

  // implemented bits; the rest read as zero
  localparam logic [7:0] VERT_CTRL_MASK = 8'h06;
  localparam logic [7:0] HORIZ_CTRL_MASK = 8'h07;
  localparam logic [7:0] INTEG_CFG_MASK = 8'h08;
  localparam logic [7:0] READ_IDLE = 8'h00;

  // field positions
  localparam int ROW_ORDER_BIT = 2;
  localparam int ROW_SKIP_BIT = 1;
  localparam int COL_ORDER_BIT = 2;
  localparam int COL_SKIP_BIT = 1;
  localparam int COL_AVG_BIT = 0;
  localparam int PARTIAL_INT_BIT = 3;

  // address strides
  localparam int STRIDE_FULL = 1;
  localparam int STRIDE_SKIP = 2;

  typedef enum logic [1:0] {
    SCAN_IDLE,
    SCAN_ARM,
    SCAN_RUN
  } scan_state_t;

endpackage

// [src/shadow_reg.sv]
// double-buffered register: shadow written by software, active loaded at frame boundary
`timescale 1ns/100ps
`default_nettype none

module shadow_reg
  import scan_readout_pkg::*;
#(
  parameter int W = 8,
  parameter logic [W-1:0] RST = '0,
  parameter logic [W-1:0] MASK = '1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // software side
  input wire logic wr_en_in,
  input wire logic [W-1:0] wr_data_in,
  // frame boundary
  input wire logic load_in,
  // values
  output logic [W-1:0] shadow_out,
  output logic [W-1:0] active_out
);

  typedef struct packed {
    logic [W-1:0] shadow;
    logic [W-1:0] active;
  } sreg_t;

  sreg_t q_ff;
  sreg_t nxt_q;

  // a write in the load cycle lands in the shadow; active takes the older value
  always_comb begin
    nxt_q = q_ff;
    if (wr_en_in) begin
      nxt_q.shadow = wr_data_in & MASK;
    end
    if (load_in) begin
      nxt_q.active = q_ff.shadow;
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_ff <= '{shadow: RST, active: RST};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign shadow_out = q_ff.shadow;
  assign active_out = q_ff.active;

endmodule

`default_nettype wire

// [src/addr_stepper.sv]
// row or column address walker with direction and skip
`timescale 1ns/100ps
`default_nettype none

module addr_stepper
  import scan_readout_pkg::*;
#(
  parameter int N = 64,
  parameter int W = $clog2(N)
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // control
  input wire logic start_in,
  input wire logic step_in,
  input wire logic reverse_in,
  input wire logic skip_in,
  // address
  output logic [W-1:0] addr_out,
  output logic last_out
);

  localparam logic [W-1:0] LAST_IDX = W'(N - 1);

  typedef struct packed {
    logic [W-1:0] addr;
  } step_t;

  step_t q_ff;
  step_t nxt_q;
  logic [W-1:0] stride;

  always_comb begin
    stride = skip_in ? W'(STRIDE_SKIP) : W'(STRIDE_FULL);
    nxt_q = q_ff;
    if (start_in) begin
      nxt_q.addr = reverse_in ? LAST_IDX : '0;
    end else if (step_in) begin
      nxt_q.addr = reverse_in ? q_ff.addr - stride : q_ff.addr + stride;
    end
  end

  // last when one more stride would leave the array
  assign last_out = reverse_in ? (q_ff.addr < stride) : (q_ff.addr > LAST_IDX - stride);
  assign addr_out = q_ff.addr;

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_ff <= '0;
    end else begin
      q_ff <= nxt_q;
    end
  end

endmodule

`default_nettype wire

// [src/scan_readout_config.sv]
// scan readout configuration: double-buffered scan registers and row/column sequencing
//
// How it works
// - row order bit 1 (default) scans top to bottom, 0 bottom to top.
// - row skip bit 1 skips rows; 0 (default) reads every row.
// - column order bit 1 (default) reads left to right, 0 right to left.
// - column skip bit 1 skips columns; 0 (default) reads every column.
// - column average bit 1 averages neighbouring columns; 0 (default) none.
// - partial frame integration bit 1 (default) integrates per partial frame.
// - clearing partial frame integration bit turns partial frame integration off.
//
// Design decision made here: the strobed register port.
`timescale 1ns/100ps
`default_nettype none

module scan_readout_config
  import scan_readout_pkg::*;
#(
  parameter int ROWS = 64,
  parameter int COLS = 64,
  parameter int PIX_W = 8,
  parameter int ROW_W = $clog2(ROWS),
  parameter int COL_W = $clog2(COLS)
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic reset_in,
  // register port
  input wire logic [REG_ADDR_W-1:0] reg_addr_in,
  input wire logic [REG_DATA_W-1:0] reg_wdata_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  output logic [REG_DATA_W-1:0] reg_rdata_out,
  // frame control
  input wire logic frame_start_in,
  output logic frame_busy_out,
  output logic frame_done_out,
  // pixel array addressing
  output logic [ROW_W-1:0] row_addr_out,
  output logic [COL_W-1:0] col_addr_out,
  output logic addr_valid_out,
  // pixel data, one cycle after its address
  input wire logic [PIX_W-1:0] pixel_data_in,
  output logic [PIX_W-1:0] pixel_out,
  output logic pixel_valid_out,
  output logic row_end_out,
  // integration setting for exposure timing
  output logic partial_frame_integration_enable_out
);

  typedef struct packed {
    scan_state_t st;
    logic [REG_DATA_W-1:0] rd_data;
    logic samp_valid;
    logic samp_last;
    logic pair_phase;
    logic [PIX_W-1:0] pair_first;
    logic pix_valid;
    logic [PIX_W-1:0] pix;
    logic row_end;
    logic frame_done;
  } ctl_t;

  ctl_t q_ff;
  ctl_t nxt_q;

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic accept;
  logic wr_vert;
  logic wr_horiz;
  logic wr_integ;
  logic [REG_DATA_W-1:0] vert_shadow;
  logic [REG_DATA_W-1:0] vert_active;
  logic [REG_DATA_W-1:0] horiz_shadow;
  logic [REG_DATA_W-1:0] horiz_active;
  logic [REG_DATA_W-1:0] integ_shadow;
  logic [REG_DATA_W-1:0] integ_active;

  assign accept = frame_start_in && (q_ff.st == SCAN_IDLE);
  assign wr_vert = reg_wr_in && (reg_addr_in == VERT_CTRL_ADDR);
  assign wr_horiz = reg_wr_in && (reg_addr_in == HORIZ_CTRL_ADDR);
  assign wr_integ = reg_wr_in && (reg_addr_in == INTEG_CFG_ADDR);

  // actives only move on an accepted frame start, so a frame never mixes settings
  shadow_reg #(.W(REG_DATA_W), .RST(VERT_CTRL_RST), .MASK(VERT_CTRL_MASK)) u_vert (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(wr_vert),
    .wr_data_in(reg_wdata_in),
    .load_in(accept),
    .shadow_out(vert_shadow),
    .active_out(vert_active)
  );

  shadow_reg #(.W(REG_DATA_W), .RST(HORIZ_CTRL_RST), .MASK(HORIZ_CTRL_MASK)) u_horiz (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(wr_horiz),
    .wr_data_in(reg_wdata_in),
    .load_in(accept),
    .shadow_out(horiz_shadow),
    .active_out(horiz_active)
  );

  // low reserved bits are masked off, so a careless host cannot disturb them
  shadow_reg #(.W(REG_DATA_W), .RST(INTEG_CFG_RST), .MASK(INTEG_CFG_MASK)) u_integ (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .wr_en_in(wr_integ),
    .wr_data_in(reg_wdata_in),
    .load_in(accept),
    .shadow_out(integ_shadow),
    .active_out(integ_active)
  );

  logic row_fwd;
  logic row_skip;
  logic col_fwd;
  logic col_skip;
  logic col_avg;

  assign row_fwd = vert_active[ROW_ORDER_BIT];
  assign row_skip = vert_active[ROW_SKIP_BIT];
  assign col_fwd = horiz_active[COL_ORDER_BIT];
  assign col_skip = horiz_active[COL_SKIP_BIT];
  assign col_avg = horiz_active[COL_AVG_BIT];
  assign partial_frame_integration_enable_out = integ_active[PARTIAL_INT_BIT];

  ////////////////////////////////////////////////////////////////////////
  // address walkers

  logic row_last;
  logic col_last;
  logic running;
  logic arming;
  logic col_restart;
  logic col_adv;
  logic row_adv;

  assign running = (q_ff.st == SCAN_RUN);
  assign arming = (q_ff.st == SCAN_ARM);
  assign col_restart = arming || (running && col_last);
  assign col_adv = running && !col_last;
  assign row_adv = running && col_last && !row_last;

  addr_stepper #(.N(ROWS), .W(ROW_W)) u_rows (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(arming),
    .step_in(row_adv),
    .reverse_in(!row_fwd),
    .skip_in(row_skip),
    .addr_out(row_addr_out),
    .last_out(row_last)
  );

  addr_stepper #(.N(COLS), .W(COL_W)) u_cols (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .start_in(col_restart),
    .step_in(col_adv),
    .reverse_in(!col_fwd),
    .skip_in(col_skip),
    .addr_out(col_addr_out),
    .last_out(col_last)
  );

  ////////////////////////////////////////////////////////////////////////
  // sequencing, pixel path and read-back

  logic [PIX_W:0] pair_sum;

  assign pair_sum = {1'b0, q_ff.pair_first} + {1'b0, pixel_data_in};

  always_comb begin
    nxt_q = q_ff;
    nxt_q.frame_done = 1'b0;
    case (q_ff.st)
      SCAN_IDLE: begin
        if (accept) begin
          nxt_q.st = SCAN_ARM;
        end
      end
      SCAN_ARM: begin
        nxt_q.st = SCAN_RUN;
      end
      SCAN_RUN: begin
        if (col_last && row_last) begin
          nxt_q.st = SCAN_IDLE;
          nxt_q.frame_done = 1'b1;
        end
      end
      default: begin
        nxt_q.st = SCAN_IDLE;
      end
    endcase
    nxt_q.samp_valid = running;
    nxt_q.samp_last = running && col_last;
    nxt_q.pix_valid = 1'b0;
    nxt_q.row_end = 1'b0;
    if (q_ff.samp_valid) begin
      if (col_avg) begin
        if (q_ff.pair_phase) begin
          nxt_q.pix = pair_sum[PIX_W:1];
          nxt_q.pix_valid = 1'b1;
          nxt_q.pair_phase = 1'b0;
        end else begin
          nxt_q.pair_first = pixel_data_in;
          nxt_q.pair_phase = 1'b1;
        end
      end else begin
        nxt_q.pix = pixel_data_in;
        nxt_q.pix_valid = 1'b1;
      end
      // an unpaired last column is dropped rather than carried into the next row
      if (q_ff.samp_last) begin
        nxt_q.pair_phase = 1'b0;
        nxt_q.row_end = 1'b1;
      end
    end
    nxt_q.rd_data = READ_IDLE;
    if (reg_rd_in) begin
      case (reg_addr_in)
        VERT_CTRL_ADDR: nxt_q.rd_data = vert_shadow;
        HORIZ_CTRL_ADDR: nxt_q.rd_data = horiz_shadow;
        INTEG_CFG_ADDR: nxt_q.rd_data = integ_shadow;
        default: nxt_q.rd_data = READ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      q_ff <= '{st: SCAN_IDLE, default: '0};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign reg_rdata_out = q_ff.rd_data;
  assign frame_busy_out = (q_ff.st != SCAN_IDLE);
  assign frame_done_out = q_ff.frame_done;
  assign addr_valid_out = running;
  assign pixel_out = q_ff.pix;
  assign pixel_valid_out = q_ff.pix_valid;
  assign row_end_out = q_ff.row_end;

  ////////////////////////////////////////////////////////////////////////
  // checks

  localparam logic [ROW_W-1:0] ROW_LAST_IDX = ROW_W'(ROWS - 1);
  localparam logic [COL_W-1:0] COL_LAST_IDX = COL_W'(COLS - 1);

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (reset_in);

  sequence seq_accepted;
    frame_start_in && (q_ff.st == SCAN_IDLE);
  endsequence

  sequence seq_arm_then_run;
    (q_ff.st == SCAN_ARM) ##1 (q_ff.st == SCAN_RUN);
  endsequence

  chk_row_start_top: assert property (
    seq_accepted ##1 (vert_active[ROW_ORDER_BIT]) |=> (row_addr_out == '0))
    else $error("row scan did not start at the top row");

  chk_row_start_bottom: assert property (
    seq_accepted ##1 (!vert_active[ROW_ORDER_BIT]) |=> (row_addr_out == ROW_LAST_IDX))
    else $error("reversed row scan did not start at the bottom row");

  chk_row_skip_stride: assert property (
    (row_adv && row_fwd && row_skip) |=> (row_addr_out == $past(row_addr_out) + ROW_W'(STRIDE_SKIP)))
    else $error("row skip did not advance by the skip stride");

  chk_row_full_stride: assert property (
    (row_adv && !row_fwd && !row_skip) |=> (row_addr_out == $past(row_addr_out) - ROW_W'(STRIDE_FULL)))
    else $error("row scan without skip missed a row");

  chk_col_start_side: assert property (
    seq_accepted |=> seq_arm_then_run ##0 (col_addr_out == (col_fwd ? '0 : COL_LAST_IDX)))
    else $error("column scan started at the wrong side");

  chk_col_stride: assert property (
    (col_adv && col_fwd) |=> (col_addr_out == $past(col_addr_out)
      + (($past(col_skip)) ? COL_W'(STRIDE_SKIP) : COL_W'(STRIDE_FULL))))
    else $error("column step differs from the selected stride");

  chk_avg_pair_out: assert property (
    (q_ff.samp_valid && col_avg && q_ff.pair_phase)
      |=> pixel_valid_out && (pixel_out == $past(pair_sum[PIX_W:1])))
    else $error("averaged pixel is not the mean of its column pair");

  chk_plain_pixel_out: assert property (
    (q_ff.samp_valid && !col_avg) |=> pixel_valid_out && (pixel_out == $past(pixel_data_in)))
    else $error("pixel without averaging was altered or lost");

  chk_partial_int_load: assert property (
    seq_accepted |=> (partial_frame_integration_enable_out == $past(integ_shadow[PARTIAL_INT_BIT])))
    else $error("partial integration setting not taken at frame start");

  chk_partial_int_off: assert property (
    (seq_accepted and !integ_shadow[PARTIAL_INT_BIT]) |=> !partial_frame_integration_enable_out [*2])
    else $error("cleared partial integration bit still enabled");

  chk_active_frozen: assert property (
    (q_ff.st != SCAN_IDLE) |=> $stable(vert_active) && $stable(horiz_active) && $stable(integ_active))
    else $error("active setting changed inside a frame");

endmodule

`default_nettype wire

// [verification/scan_readout_config_bench.sv]
// self-checking bench for the scan readout configuration block
`timescale 1ns/100ps
`default_nettype none

module scan_readout_config_bench import scan_readout_pkg::*;;
  localparam int ROWS = 4;
  localparam int COLS = 4;

  logic clk_in = 1'b0;
  logic reset_in;
  logic [7:0] reg_addr_in;
  logic [7:0] reg_wdata_in;
  logic reg_wr_in;
  logic reg_rd_in;
  logic [7:0] reg_rdata_out;
  logic frame_start_in;
  logic frame_busy_out;
  logic frame_done_out;
  logic [$clog2(ROWS)-1:0] row_addr_out;
  logic [$clog2(COLS)-1:0] col_addr_out;
  logic addr_valid_out;
  logic [7:0] pixel_data_in;
  logic [7:0] pixel_out;
  logic pixel_valid_out;
  logic row_end_out;
  logic partial_frame_integration_enable_out;

  int seed = 32'hdfc2;
  int fails;
  int cmp_count;
  int row_ends;
  logic [7:0] sh_v, sh_h, sh_i, act_h, held, pd;
  logic have, rd_d, done_seen;
  logic [7:0] rd_q[$];
  logic [7:0] addr_q[$];
  logic [7:0] pix_q[$];

  always #2 clk_in = ~clk_in;

  scan_readout_config #(.ROWS(ROWS), .COLS(COLS)) DUT (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in),
    .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out),
    .frame_start_in(frame_start_in),
    .frame_busy_out(frame_busy_out),
    .frame_done_out(frame_done_out),
    .row_addr_out(row_addr_out),
    .col_addr_out(col_addr_out),
    .addr_valid_out(addr_valid_out),
    .pixel_data_in(pixel_data_in),
    .pixel_out(pixel_out),
    .pixel_valid_out(pixel_valid_out),
    .row_end_out(row_end_out),
    .partial_frame_integration_enable_out(partial_frame_integration_enable_out)
  );

  ////////////////////////////////////////////////////////////////////////////////
  task automatic compare(input string what, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // strobes stay up so calls run back to back; idle() drops them
  task automatic reg_op(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (r) rd_q.push_back(a == VERT_CTRL_ADDR ? sh_v : a == HORIZ_CTRL_ADDR ? sh_h :
                          a == INTEG_CFG_ADDR ? sh_i : 8'h00);
    if (w && a == VERT_CTRL_ADDR) sh_v = d & VERT_CTRL_MASK;
    if (w && a == HORIZ_CTRL_ADDR) sh_h = d & HORIZ_CTRL_MASK;
    if (w && a == INTEG_CFG_ADDR) sh_i = d & INTEG_CFG_MASK;
  endtask

  task automatic idle();
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
  endtask

  // one frame on the loaded settings; next settings written mid-frame with random reserved bits
  task automatic run_frame(input logic [4:0] k);
    logic [7:0] v, h;
    int n, nr;
    v = {5'h00, ~k[4], k[3], 1'b0} | (8'($random(seed)) & ~VERT_CTRL_MASK);
    h = {5'h00, ~k[2], k[1:0]} | (8'($random(seed)) & ~HORIZ_CTRL_MASK);
    @(posedge clk_in);
    frame_start_in <= 1'b1;
    act_h = sh_h;
    have = 1'b0;
    done_seen = 1'b0;
    nr = 0;
    row_ends = 0;
    for (int i = 0; i < ROWS; i += (sh_v[ROW_SKIP_BIT] ? STRIDE_SKIP : STRIDE_FULL)) begin
      nr++;
      for (int j = 0; j < COLS; j += (sh_h[COL_SKIP_BIT] ? STRIDE_SKIP : STRIDE_FULL)) begin
        addr_q.push_back(8'((sh_v[ROW_ORDER_BIT] ? i : ROWS - 1 - i) * COLS +
                            (sh_h[COL_ORDER_BIT] ? j : COLS - 1 - j)));
      end
    end
    @(posedge clk_in);
    // start held into the busy cycle: that second request must vanish
    @(posedge clk_in);
    frame_start_in <= 1'b0;
    reg_op(1'b1, 1'b0, VERT_CTRL_ADDR, v);
    reg_op(1'b1, 1'b0, HORIZ_CTRL_ADDR, h);
    reg_op(1'b0, 1'b1, VERT_CTRL_ADDR, 8'h00);
    reg_op(1'b0, 1'b1, HORIZ_CTRL_ADDR, 8'h00);
    idle();
    for (n = 0; n < 100 && !done_seen; n++) @(posedge clk_in);
    if (!done_seen) begin
      compare("frame done", 8'h01, 8'h00);
      give_verdict();
    end
    // last row end trails frame done by one cycle
    repeat (2) @(posedge clk_in);
    compare("row ends", 8'(nr), 8'(row_ends));
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    pd = 8'($random(seed));
    pixel_data_in <= pd;
    if (addr_valid_out && !act_h[COL_AVG_BIT]) pix_q.push_back(pd);
    if (addr_valid_out && act_h[COL_AVG_BIT] && have) pix_q.push_back(8'((9'(held) + 9'(pd)) >> 1));
    if (addr_valid_out && act_h[COL_AVG_BIT]) begin
      held = pd;
      have = ~have;
    end
  end

  always @(posedge clk_in) begin
    rd_d <= reg_rd_in && !reset_in;
    if (frame_done_out) done_seen = 1'b1;
    if (row_end_out) row_ends++;
    if (frame_done_out) compare("busy at frame end", 8'h00, {7'h00, frame_busy_out});
    if (addr_valid_out) compare("busy in frame", 8'h01, {7'h00, frame_busy_out});
    if (rd_d) compare("read data", rd_q.size() ? rd_q.pop_front() : 8'hxx, reg_rdata_out);
    if (addr_valid_out) compare("array address", addr_q.size() ? addr_q.pop_front() : 8'hxx,
                                8'({row_addr_out, col_addr_out}));
    if (pixel_valid_out) compare("pixel", pix_q.size() ? pix_q.pop_front() : 8'hxx, pixel_out);
  end

  initial begin
    reset_in <= 1'b1;
    reg_addr_in <= 8'h00;
    reg_wdata_in <= 8'h00;
    reg_wr_in <= 1'b0;
    reg_rd_in <= 1'b0;
    frame_start_in <= 1'b0;
    pixel_data_in <= 8'h00;
    fails = 0;
    cmp_count = 0;
    sh_v = VERT_CTRL_RST;
    sh_h = HORIZ_CTRL_RST;
    sh_i = INTEG_CFG_RST;
    act_h = HORIZ_CTRL_RST;
    have = 1'b0;
    done_seen = 1'b0;
    repeat (20) @(posedge clk_in);
    reset_in <= 1'b0;
    reg_op(1'b0, 1'b1, VERT_CTRL_ADDR, 8'h00);
    reg_op(1'b0, 1'b1, HORIZ_CTRL_ADDR, 8'h00);
    reg_op(1'b0, 1'b1, INTEG_CFG_ADDR, 8'h00);
    reg_op(1'b1, 1'b0, 8'h12, 8'($random(seed)));
    reg_op(1'b0, 1'b1, 8'h12, 8'h00);
    idle();
    compare("integration enable", 8'h01, {7'h00, partial_frame_integration_enable_out});
    $display("test register reset done");
    for (int k = 0; k < 32; k++) run_frame(5'(k + 1));
    $display("test scan modes done");
    reg_op(1'b1, 1'b0, INTEG_CFG_ADDR, 8'h00);
    reg_op(1'b0, 1'b1, INTEG_CFG_ADDR, 8'h00);
    idle();
    compare("integration enable", 8'h01, {7'h00, partial_frame_integration_enable_out});
    run_frame(5'd0);
    compare("integration enable", 8'h00, {7'h00, partial_frame_integration_enable_out});
    reg_op(1'b1, 1'b0, INTEG_CFG_ADDR, 8'h08);
    idle();
    run_frame(5'd0);
    compare("integration enable", 8'h01, {7'h00, partial_frame_integration_enable_out});
    $display("test partial frame integration done");
    repeat (10) @(posedge clk_in);
    compare("outstanding results", 8'h00, 8'(addr_q.size() + pix_q.size() + rd_q.size()));
    give_verdict();
  end
endmodule

`default_nettype wire
